// ### rtl/ddt_top.sv
// What this block does
// RL1 - With chop-four fixed by mode, power-down entry waits write latency plus 2 plus write recovery cycles after a write.
// RL2 - With chop-four fixed by mode, power-down after an auto-precharge write waits write latency plus 2 plus programmed recovery plus 1.
// RL3 - Termination turns on and off write latency minus two clocks after odt is seen high or low.
// RL4 - The controller holds odt high for a short count without or with a chopped write, and a longer count with an eight-beat write.
// RL5 - In power-down with the dll frozen termination follows odt directly within 2 to 8.5 ns.
// RL6 - Termination finishes turning off within 0.3 to 0.7 clock periods of its turn-off reference.
// RL7 - The first strobe rise comes at least 40 clocks after leveling mode is set.
// RL8 - The strobe pair is driven no sooner than 25 clocks after leveling mode is set.
// RL9 - In leveling the sampled clock level returns on the data line within 0 to 7.5 ns of a strobe rise, with up to 2 ns error.
// RL10 - Cycle spacings are counted in real clock edges.
// RL11 - A nanosecond figure becomes cycles by dividing by the clock period and rounding up.
// RL12 - For eight-beat or on-the-fly chop writes power-down waits write latency plus 4 plus write recovery cycles.
// RL13 - Write recovery over the clock period is rounded up for the power-down spacing.
// RL14 - For eight-beat or on-the-fly auto-precharge writes power-down waits write latency plus 4 plus programmed recovery plus 1.
//
// Design decisions made here: register access over Wishbone and the register addresses.
module ddt_top
  import ddt_pkg::*;
#(
  parameter int LAT_W = 5,
  parameter int ODT_DEPTH = 32
) (
  input wire logic clk,              // 10 MHz clock
  input wire logic rst_n,            // async reset, active low
  input wire logic ce,               // clock enable, freezes state
  input wire logic wb_cyc_i,         // wishbone cycle
  input wire logic wb_stb_i,         // wishbone strobe
  input wire logic wb_we_i,          // wishbone write
  input wire logic [3:0] wb_adr_i,   // byte address
  input wire logic [3:0] wb_sel_i,   // byte lanes
  input wire logic [31:0] wb_dat_i,  // write data
  output logic [31:0] wb_dat_o,      // read data
  output logic wb_ack_o,             // acknowledge
  input wire ddt_cmd_s cmd,          // registered command
  input wire logic cke,              // clock enable pin
  input wire logic odt,              // termination request
  input wire logic dqs,              // strobe level
  input wire logic dqs_drv,          // strobe pair driven
  input wire logic ck_at_dqs,        // clock level at strobe edge
  output logic term_en,              // termination on
  output logic lvl_dq,               // leveling feedback
  output logic lvl_dq_oe             // feedback drive enable
);

  generate
    if (LAT_W < 5 || ODT_DEPTH < (1 << LAT_W)) begin : g_bad
      $error("ddt_top: latency width or odt depth too small");
    end
  endgenerate

  // true when the bus address selects a register
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction

  // byte-lane merge of a write into a register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [7:0] twr_ns_ff, nxt_twr_ns;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic pd_early_ff, nxt_pd_early;
  logic cke_prev_ff, nxt_cke_prev;
  logic [7:0] since_ff, nxt_since;
  logic [7:0] req_ff, nxt_req;
  logic armed_ff, nxt_armed;

  ddt_ctrl_s ctrl;
  logic acc, wr_go;
  logic [4:0] wl;
  logic [LAT_W-1:0] term_lat;
  logic [7:0] twr_cyc;
  logic pd_entry;
  logic clr_pd, clr_strobe, clr_drive;
  logic early_strobe, early_drive;
  logic term_en_w, lvl_dq_w, lvl_oe_w;
  logic [31:0] stat;

  // decoded control and derived latencies
  always_comb begin
    ctrl = ddt_ctrl_s'(ctrl_ff);
    wl = {1'b0, ctrl.column_write_latency} +
         {1'b0, ctrl.additive_latency};
    // latency is write latency minus two, never below zero
    term_lat = (wl > TERM_LAT_OFS) ?
               LAT_W'(wl - TERM_LAT_OFS) : '0; // RL3
    twr_cyc = ns_to_cyc(twr_ns_ff); // RL11 RL13
  end

  // bus access: ack one cycle after request, write lands at the ack edge
  always_comb begin
    acc = wb_cyc_i & wb_stb_i;
    wr_go = acc & wb_we_i & ack_ff;
    nxt_ack = acc & ~ack_ff;
    clr_pd = wr_go & hit(wb_adr_i, ADR_STAT) & wb_sel_i[0] &
             wb_dat_i[STAT_PD_EARLY];
    clr_strobe = wr_go & hit(wb_adr_i, ADR_STAT) & wb_sel_i[0] &
                 wb_dat_i[STAT_LVL_STROBE];
    clr_drive = wr_go & hit(wb_adr_i, ADR_STAT) & wb_sel_i[0] &
                wb_dat_i[STAT_LVL_DRIVE];
    nxt_ctrl = ctrl_ff;
    nxt_twr_ns = twr_ns_ff;
    if (wr_go && hit(wb_adr_i, ADR_CTRL)) begin
      nxt_ctrl = merge(ctrl_ff, wb_dat_i, wb_sel_i) & CTRL_WMASK;
    end
    if (wr_go && hit(wb_adr_i, ADR_TWR) && wb_sel_i[0]) begin
      nxt_twr_ns = wb_dat_i[7:0];
    end
  end

  // status word seen by software
  always_comb begin
    stat = '0;
    stat[STAT_TERM] = term_en_w;
    stat[STAT_PD_EARLY] = pd_early_ff;
    stat[STAT_LVL_STROBE] = early_strobe;
    stat[STAT_LVL_DRIVE] = early_drive;
    stat[STAT_IN_PD] = ~cke_prev_ff;
    // unmapped addresses read as zero but are still acknowledged
    nxt_rdat = '0;
    if (nxt_ack && !wb_we_i) begin
      if (hit(wb_adr_i, ADR_CTRL)) begin
        nxt_rdat = ctrl_ff;
      end else if (hit(wb_adr_i, ADR_STAT)) begin
        nxt_rdat = stat;
      end else if (hit(wb_adr_i, ADR_TWR)) begin
        nxt_rdat = {24'h00_0000, twr_ns_ff};
      end
    end
  end

  // write to power-down spacing, counted in clock edges since the write
  always_comb begin
    pd_entry = cke_prev_ff & ~cke;
    nxt_cke_prev = cke;
    nxt_since = since_ff;
    nxt_req = req_ff;
    nxt_armed = armed_ff;
    if (cmd.valid && cmd.write) begin
      nxt_since = 8'h01; // RL10
      nxt_armed = 1'b1;
      nxt_req = {3'b000, wl} +
                (ctrl.chop4_fixed ? WR_PD_OFS_CHOP4 : WR_PD_OFS_BL8);
      if (cmd.auto_pre) begin
        // auto-precharge uses the programmed recovery plus one
        nxt_req = nxt_req + {3'b000, ctrl.wr_prog} + WR_AP_EXTRA; // RL2 RL14
      end else begin
        nxt_req = nxt_req + twr_cyc; // RL1 RL12
      end
    end else if (armed_ff && since_ff != 8'hff) begin
      nxt_since = since_ff + 8'h01;
    end
    // a fresh violation wins over a clear in the same cycle
    nxt_pd_early = (pd_early_ff & ~clr_pd) |
                   (pd_entry & armed_ff & (since_ff < req_ff)); // RL1 RL12
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
      twr_ns_ff <= TWR_NS_RST;
      ack_ff <= 1'b0;
      rdat_ff <= '0;
      pd_early_ff <= 1'b0;
      cke_prev_ff <= 1'b0;
      since_ff <= '0;
      req_ff <= '0;
      armed_ff <= 1'b0;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
      twr_ns_ff <= nxt_twr_ns;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      pd_early_ff <= nxt_pd_early;
      cke_prev_ff <= nxt_cke_prev;
      since_ff <= nxt_since;
      req_ff <= nxt_req;
      armed_ff <= nxt_armed;
    end
  end

  // termination latency pipe
  ddt_odt_ctl #(
    .LAT_W(LAT_W),
    .DEPTH(ODT_DEPTH)
  ) u_odt (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .odt(odt),
    .pd_frozen(ctrl.pd_frozen & ~cke_prev_ff),
    .lat(term_lat),
    .term_en(term_en_w)
  );

  // write leveling feedback and wait checks
  ddt_wrlvl u_lvl (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .level_en(ctrl.level_en),
    .dqs(dqs),
    .dqs_drv(dqs_drv),
    .ck_at_dqs(ck_at_dqs),
    .clr_strobe(clr_strobe),
    .clr_drive(clr_drive),
    .fb_dq(lvl_dq_w),
    .fb_oe(lvl_oe_w),
    .early_strobe(early_strobe),
    .early_drive(early_drive)
  );

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
  assign term_en = term_en_w;
  assign lvl_dq = lvl_dq_w;
  assign lvl_dq_oe = lvl_oe_w;

endmodule // ddt_top

// ### rtl/ddt_pkg.sv
package ddt_pkg;

  // bus clock and derived cycle figures
  localparam int CLK_PERIOD_PS = 100000;
  localparam int CLK_PERIOD_NS = 100;

  // register byte addresses
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_TWR = 4'h8;

  // control register layout, msb first
  typedef struct packed {
    logic [10:0] rsvd_hi;   // [31:21]
    logic [4:0] wr_prog;    // [20:16] write recovery in cycles
    logic [4:0] rsvd_lo;    // [15:11]
    logic level_en;         // [10] write leveling mode
    logic pd_frozen;        // [9] power-down with dll frozen
    logic chop4_fixed;      // [8] chop-four fixed by mode
    logic [3:0] additive_latency;       // [7:4]
    logic [3:0] column_write_latency;   // [3:0]
  } ddt_ctrl_s;

  localparam logic [31:0] CTRL_RST = 32'h0006_0005;
  localparam logic [31:0] CTRL_WMASK = 32'h001f_07ff;
  localparam logic [7:0] TWR_NS_RST = 8'h0f;

  // status register bit positions
  localparam int STAT_TERM = 0;
  localparam int STAT_PD_EARLY = 1;
  localparam int STAT_LVL_STROBE = 2;
  localparam int STAT_LVL_DRIVE = 3;
  localparam int STAT_IN_PD = 4;

  // command strobe from the controller, one per registered command
  typedef struct packed {
    logic valid;
    logic write;
    logic auto_pre;
  } ddt_cmd_s;

  // write-to-power-down spacing offsets, and the termination latency offset
  localparam logic [7:0] WR_PD_OFS_CHOP4 = 8'h02;
  localparam logic [7:0] WR_PD_OFS_BL8 = 8'h04;
  localparam logic [7:0] WR_AP_EXTRA = 8'h01;
  localparam logic [4:0] TERM_LAT_OFS = 5'h02;

  // write leveling waits, in clock edges
  localparam logic [5:0] LEVEL_FIRST_STROBE_WAIT = 6'h28;
  localparam logic [5:0] LEVEL_STROBE_DRIVE_WAIT = 6'h19;

  // sub-cycle delays: longest rounds down, floor one
  localparam int ASYNC_TERM_DELAY_MAX_PS = 8500;
  localparam int ASYNC_TERM_CYC =
    (ASYNC_TERM_DELAY_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 :
    ASYNC_TERM_DELAY_MAX_PS / CLK_PERIOD_PS;
  localparam int LEVEL_FEEDBACK_DELAY_MAX_PS = 7500;
  localparam int LEVEL_FEEDBACK_CYC =
    (LEVEL_FEEDBACK_DELAY_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 :
    LEVEL_FEEDBACK_DELAY_MAX_PS / CLK_PERIOD_PS;

  // ns to cycles, rounded up
  function automatic logic [7:0] ns_to_cyc(input logic [7:0] ns);
    logic [8:0] sum;
    sum = {1'b0, ns} + 9'(CLK_PERIOD_NS - 1);
    return 8'(sum / 9'(CLK_PERIOD_NS));
  endfunction

endpackage

// ### rtl/ddt_odt_ctl.sv
module ddt_odt_ctl
  import ddt_pkg::*;
#(
  parameter int LAT_W = 5,
  parameter int DEPTH = 32
) (
  input wire logic clk,              // bus clock
  input wire logic rst_n,            // async reset, active low
  input wire logic ce,               // clock enable
  input wire logic odt,              // termination request pin
  input wire logic pd_frozen,        // power-down with dll frozen
  input wire logic [LAT_W-1:0] lat,  // turn-on/off latency in cycles
  output logic term_en               // termination active
);

  generate
    if (DEPTH < (1 << LAT_W) || ASYNC_TERM_CYC != 1) begin : g_bad
      $error("ddt_odt_ctl: depth too small or delay not one cycle");
    end
  endgenerate

  logic [DEPTH-1:0] hist_ff;
  logic [DEPTH-1:0] nxt_hist;
  logic term_ff;
  logic nxt_term;

  // history of odt, one bit per clock edge
  always_comb begin
    nxt_hist = {hist_ff[DEPTH-2:0], odt};
    nxt_term = term_ff;
    if (pd_frozen) begin
      nxt_term = odt; // RL5
    end else if (lat == '0) begin
      nxt_term = odt;
    end else begin
      // on and off share one latency; off completes inside this cycle
      nxt_term = hist_ff[lat - LAT_W'(1)]; // RL3 RL6
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_ff <= '0;
      term_ff <= 1'b0;
    end else if (ce) begin
      hist_ff <= nxt_hist;
      term_ff <= nxt_term;
    end
  end

  assign term_en = term_ff;

endmodule // ddt_odt_ctl

// ### rtl/ddt_wrlvl.sv
module ddt_wrlvl
  import ddt_pkg::*;
(
  input wire logic clk,        // bus clock
  input wire logic rst_n,      // async reset, active low
  input wire logic ce,         // clock enable
  input wire logic level_en,   // write leveling mode on
  input wire logic dqs,        // strobe level
  input wire logic dqs_drv,    // controller drives strobe pair
  input wire logic ck_at_dqs,  // clock level caught by strobe edge
  input wire logic clr_strobe, // clear early strobe flag
  input wire logic clr_drive,  // clear early drive flag
  output logic fb_dq,          // sampled clock level fed back
  output logic fb_oe,          // feedback drive enable
  output logic early_strobe,   // strobe rose before its wait
  output logic early_drive     // strobe driven before its wait
);

  generate
    if (LEVEL_FEEDBACK_CYC != 1) begin : g_bad
      $error("ddt_wrlvl: feedback must fit one cycle");
    end
  endgenerate

  logic [5:0] cnt_ff, nxt_cnt;
  logic dqs_prev_ff, nxt_dqs_prev;
  logic fb_ff, nxt_fb;
  logic oe_ff, nxt_oe;
  logic es_ff, nxt_es;
  logic ed_ff, nxt_ed;
  logic dqs_rise;

  // edges since leveling mode was set, saturating at the longest wait
  always_comb begin
    dqs_rise = dqs & ~dqs_prev_ff & level_en;
    nxt_dqs_prev = dqs;
    nxt_cnt = cnt_ff;
    if (!level_en) begin
      nxt_cnt = '0;
    end else if (cnt_ff < LEVEL_FIRST_STROBE_WAIT) begin
      nxt_cnt = cnt_ff + 6'h01; // RL10
    end
    nxt_fb = fb_ff;
    if (dqs_rise) begin
      nxt_fb = ck_at_dqs; // RL9
    end
    nxt_oe = level_en;
    // a new violation beats a clear in the same cycle
    nxt_es = (es_ff & ~clr_strobe) |
             (dqs_rise & (cnt_ff < LEVEL_FIRST_STROBE_WAIT)); // RL7
    nxt_ed = (ed_ff & ~clr_drive) |
             (level_en & dqs_drv &
              (cnt_ff < LEVEL_STROBE_DRIVE_WAIT)); // RL8
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      dqs_prev_ff <= 1'b0;
      fb_ff <= 1'b0;
      oe_ff <= 1'b0;
      es_ff <= 1'b0;
      ed_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      dqs_prev_ff <= nxt_dqs_prev;
      fb_ff <= nxt_fb;
      oe_ff <= nxt_oe;
      es_ff <= nxt_es;
      ed_ff <= nxt_ed;
    end
  end

  assign fb_dq = fb_ff;
  assign fb_oe = oe_ff;
  assign early_strobe = es_ff;
  assign early_drive = ed_ff;

endmodule // ddt_wrlvl

// ### sim/ddt_top_asserts.sv
module ddt_top_asserts
  import ddt_pkg::*;
#(
  parameter int ODT_DEPTH = 32
) (
  input logic clk, // clock
  input logic rst_n, // reset, active low
  input logic ce, // clock enable
  input logic wb_cyc_i, // bus cycle
  input logic wb_stb_i, // bus strobe
  input logic wb_we_i, // bus write
  input logic [3:0] wb_adr_i, // byte address
  input logic [3:0] wb_sel_i, // byte lanes
  input logic [31:0] wb_dat_i, // write data
  input logic [31:0] wb_dat_o, // read data
  input logic wb_ack_o, // acknowledge
  input logic cke, // clock enable pin
  input logic odt, // termination request
  input logic dqs, // strobe level
  input logic dqs_drv, // strobe driven
  input logic ck_at_dqs, // clock at strobe
  input logic term_en, // termination on
  input logic lvl_dq, // leveling feedback
  input logic lvl_dq_oe // feedback enable
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [31:0] ctrl_ff, nxt_ctrl, lane;
  logic [ODT_DEPTH-1:0] hist_ff, nxt_hist;
  logic [5:0] quiet_ff, nxt_quiet;
  logic [4:0] sum, lat;
  logic pd_ff, nxt_pd, frz, ctl_wr;

  // shadow control, odt history; settle count masks latency changes
  always_comb begin
    lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
      {8{wb_sel_i[0]}}};
    ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
      wb_adr_i == ADR_CTRL;
    nxt_ctrl = ctl_wr ? ((ctrl_ff & ~lane) | (wb_dat_i & lane)) &
      CTRL_WMASK : ctrl_ff;
    nxt_hist = {hist_ff[ODT_DEPTH-2:0], odt};
    nxt_pd = !cke;
    frz = ctrl_ff[9] && pd_ff;
    nxt_quiet = (ctl_wr || frz) ? 6'h0 :
      quiet_ff + 6'(quiet_ff != 6'h3f);
    sum = {1'b0, ctrl_ff[3:0]} + {1'b0, ctrl_ff[7:4]};
    lat = (sum < 5'h2) ? 5'h0 : sum - 5'h2;
  end

  // helper registers, frozen with the design while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
      hist_ff <= '0;
      quiet_ff <= 6'h0;
      pd_ff <= 1'b1;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
      hist_ff <= nxt_hist;
      quiet_ff <= nxt_quiet;
      pd_ff <= nxt_pd;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  // a frozen cycle breaks every cycle count, so attempts abort there
  default disable iff (!rst_n || !ce);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    s_req ##0 !wb_we_i;
  endsequence

  property p_ack;
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a single pulse");
  property p_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data not idle");
  property p_ctrl_rd;
    s_rd ##0 (wb_adr_i == ADR_CTRL) |=> wb_dat_o == ctrl_ff;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control readback wrong");
  property p_hole;
    s_rd ##0 (wb_adr_i == 4'hc) |=> wb_dat_o == 32'h0;
  endproperty
  a_hole: assert property (p_hole)
    else $error("unmapped read not zero");
  property p_stat_term;
    s_rd ##0 (wb_adr_i == ADR_STAT) |=> wb_dat_o[STAT_TERM] == $past(term_en);
  endproperty
  a_stat_term: assert property (p_stat_term)
    else $error("status term bit wrong");
  property p_term_lat;
    quiet_ff > 6'h21 |-> term_en == hist_ff[lat];
  endproperty
  a_term_lat: assert property (p_term_lat)
    else $error("termination latency wrong");
  property p_term_frz;
    frz && $past(frz) |-> term_en == $past(odt);
  endproperty
  a_term_frz: assert property (p_term_frz)
    else $error("frozen termination wrong");
  property p_lvl_fb;
    ctrl_ff[10] && dqs_drv && $rose(dqs) |=> lvl_dq == $past(ck_at_dqs);
  endproperty
  a_lvl_fb: assert property (p_lvl_fb)
    else $error("leveling feedback wrong");
  property p_lvl_oe;
    lvl_dq_oe == $past(ctrl_ff[10]);
  endproperty
  a_lvl_oe: assert property (p_lvl_oe)
    else $error("feedback enable wrong");
endmodule // ddt_top_asserts

bind ddt_top ddt_top_asserts #(.ODT_DEPTH(ODT_DEPTH)) chk_u (.clk, .rst_n, .ce,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .cke, .odt, .dqs, .dqs_drv, .ck_at_dqs, .term_en,
  .lvl_dq, .lvl_dq_oe);

// ### sim/ddt_mc_model.sv
module ddt_mc_model
  import ddt_pkg::*;
#(
  parameter int TERM_HOLD_SHORT = 4, // odt high, no or chopped write
  parameter int TERM_HOLD_LONG = 6 // odt high, eight-beat write
) (
  input logic clk, // clock
  output ddt_cmd_s cmd, // command strobe
  output logic cke, // clock enable pin
  output logic odt, // termination request
  output logic dqs, // strobe level
  output logic dqs_drv, // strobe driven
  output logic ck_at_dqs // clock at strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  // strobe starts released, showing high
  initial begin
    cmd = '0;
    cke = 1'b1;
    odt = 1'b0;
    dqs = 1'b1;
    dqs_drv = 1'b0;
    ck_at_dqs = 1'b0;
  end

  // write then power-down, early by the given edges on request
  task automatic wr_pd(input int wl, input bit c4, input bit ap,
    input int wr, input int twr, input int early);
    int req;
    req = wl + (c4 ? 2 : 4) + (ap ? wr + 1 :
      (twr + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    @(posedge clk);
    cmd <= '{1'b1, 1'b1, ap};
    @(posedge clk);
    cmd <= '0;
    repeat (req - early - 1) @(posedge clk);
    cke <= 1'b0;
    repeat (4) @(posedge clk);
    cke <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // odt pulse held for its minimum
  task automatic hold_odt(input bit bl8);
    @(posedge clk);
    odt <= 1'b1;
    repeat (bl8 ? TERM_HOLD_LONG : TERM_HOLD_SHORT) @(posedge clk);
    odt <= 1'b0;
  endtask

  // power-down with random odt; cke stays low
  task automatic frz_run(input int n);
    @(posedge clk);
    cke <= 1'b0;
    repeat (n) begin
      @(posedge clk);
      odt <= 1'($urandom);
    end
    @(posedge clk);
    odt <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pd_exit();
    @(posedge clk);
    cke <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // drive strobe after d edges, first rise after s edges
  task automatic level(input int d, input int s);
    repeat (d) @(posedge clk);
    dqs_drv <= 1'b1;
    dqs <= 1'b0;
    repeat (s - d) @(posedge clk);
    repeat (4) begin
      dqs <= 1'b1;
      ck_at_dqs <= 1'($urandom);
      repeat (2) @(posedge clk);
      dqs <= 1'b0;
      repeat (2) @(posedge clk);
    end
    // released strobe has no keeper: shows the inverse
    dqs_drv <= 1'b0;
    dqs <= ~dqs;
  endtask
endmodule // ddt_mc_model

// ### sim/test_ddt_top.sv
module test_ddt_top
  import ddt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst_n, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rnd, exp_ctrl;
  logic cke, odt, dqs, dqs_drv, ck_at_dqs, term_en, lvl_dq, lvl_dq_oe;
  ddt_cmd_s cmd;
  logic [31:0] exp_q[$];
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  ddt_top dut_u (.clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmd, .cke,
    .odt, .dqs, .dqs_drv, .ck_at_dqs, .term_en, .lvl_dq, .lvl_dq_oe);
  ddt_mc_model mc_u (.clk, .cmd, .cke, .odt, .dqs, .dqs_drv, .ck_at_dqs);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one classic cycle; waits for ack, however long
  task automatic wbx(input logic we, input logic [3:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wbx(1'b1, a, d, 4'hf);
  endtask

  // expectation queued before the cycle starts
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wbx(1'b0, a, 32'h0, 4'hf);
  endtask

  // read data against oldest note
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) begin
      chk32(wb_dat_o, exp_q.pop_front());
    end
  end

  // hang guard, several times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    rnd = $urandom(32'h5c7d);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and the unmapped hole
    rd(ADR_CTRL, CTRL_RST);
    rd(ADR_TWR, {24'h0, TWR_NS_RST});
    rd(ADR_STAT, 32'h0);
    rd(4'hc, 32'h0);
    // top lane off; cwl kept high so latency stays positive
    rnd = $urandom | 32'h8;
    wbx(1'b1, ADR_CTRL, rnd, 4'b0111);
    exp_ctrl = ((CTRL_RST & 32'hff00_0000) | (rnd & 32'h00ff_ffff));
    rd(ADR_CTRL, exp_ctrl & CTRL_WMASK);
    // clock enable low holds a pending read without answering it
    exp_q.push_back(exp_ctrl & CTRL_WMASK);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= 1'b0;
    wb_adr_i <= ADR_CTRL;
    wb_sel_i <= 4'hf;
    ce <= 1'b0;
    repeat (8) @(posedge clk);
    chk32({31'h0, wb_ack_o}, 32'h0);
    ce <= 1'b1;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // chop, precharge and one-edge-early spacing
    for (int i = 0; i < 8; i++) begin
      rnd = $urandom_range(255, 1);
      wr(ADR_TWR, rnd);
      wr(ADR_CTRL, {11'h0, 5'h6, 7'h0, i[0], 8'h15});
      mc_u.wr_pd(6, i[0], i[1], 6, int'(rnd), i[2]);
      rd(ADR_STAT, {30'h0, i[2], 1'b0});
      wr(ADR_STAT, 32'he);
    end
    // odt latency over a spread of write latencies
    for (int c = 5; c < 11; c++) begin
      wr(ADR_CTRL, {16'h0006, 8'h0, 4'($urandom_range(3, 0)), 4'(c)});
      repeat (40) @(posedge clk);
      mc_u.hold_odt(1'b0);
      repeat (8) @(posedge clk);
      mc_u.hold_odt(1'b1);
      repeat (40) @(posedge clk);
    end
    // frozen power-down: termination follows odt at once
    wr(ADR_CTRL, 32'h0006_0205);
    mc_u.frz_run(20);
    rd(ADR_STAT, 32'h10);
    mc_u.pd_exit();
    // leveling: early strobe and drive, then in time
    for (int k = 0; k < 2; k++) begin
      wr(ADR_CTRL, 32'h0006_0405);
      mc_u.level(k ? 26 : 22, k ? 41 : 36);
      rd(ADR_STAT, k ? 32'h0 : 32'hc);
      wr(ADR_CTRL, 32'h0006_0005);
      wr(ADR_STAT, 32'he);
    end
    final_report();
  end
endmodule // test_ddt_top
